// file: dv/pos_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pos_sequencer_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [15:0] pinClaimed,
	input wire logic [15:0] claimedOut,
	input wire logic [15:0] claimedOe,
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no answer");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
	a_err_unmapped: assert property (req && wb_adr_i > 8'h23 |=> wb_err_o) else $error("no err");
	a_idle_quiet: assert property (!wb_cyc_i |=> !wb_ack_o && !wb_err_o) else $error("stray");
	a_claim_out: assert property (1'b1 |=>
		((pinOut ^ $past(claimedOut)) & $past(pinClaimed)) == 16'h0) else $error("claim out");
	a_claim_oe: assert property (1'b1 |=>
		((pinOe ^ $past(claimedOe)) & $past(pinClaimed)) == 16'h0) else $error("claim oe");
	cover property (wb_ack_o);
	cover property (wb_err_o);
	cover property (|(pinClaimed & pinOe));
endmodule : pos_sequencer_checker
bind pos_sequencer pos_sequencer_checker chk (
	.clk(clk),
	.rst_n(rst_n),
	.wb_adr_i(wb_adr_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o),
	.pinClaimed(pinClaimed),
	.claimedOut(claimedOut),
	.claimedOe(claimedOe),
	.pinOut(pinOut),
	.pinOe(pinOe)
);
`default_nettype wire

// file: dv/pos_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pos_sequencer_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ack;
	logic err;
	logic [3:0] sel = 4'h0;
	logic [15:0] req = 16'h0;
	logic [15:0] claim = 16'h0;
	logic [15:0] cOut = 16'h0;
	logic [15:0] cOe = 16'h0;
	logic [15:0] pinsIn = 16'hC35A;
	logic [15:0] pinOut;
	logic [15:0] pinOe;
	pos_pkg::pos_evt_t [3:0] evt;
	int error_cnt = 0;
	int checks_done = 0;
	always #10 clk = ~clk;
	pos_timer_model tm (.clk(clk), .req(req), .timerEvt(evt));
	pos_sequencer uut (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .timerEvt(evt), .pinClaimed(claim),
		.claimedOut(cOut), .claimedOe(cOe), .pinIn(pinsIn), .pinOut(pinOut), .pinOe(pinOe));
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic bus(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		adr <= a;
		we <= w;
		sel <= s;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(ack || err) && n < 50);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (!(ack || err)) begin
			error_cnt++;
			stop_test();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		bus(a, 1'b1, 4'hF, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		bus(a, 1'b0, 4'hF, 32'h0, q, e);
		chk("read", x, q);
	endtask : rd
	// Pulse one timer strobe, then look at the pins once the three-cycle path has settled
	task automatic fire(input logic [15:0] r, input logic [15:0] x);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= 16'h0;
		repeat (3) @(posedge clk);
		chk("pins", {16'h0000, x}, {16'h0000, pinOut});
	endtask : fire
	initial begin
		logic [31:0] q;
		logic e;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(pos_pkg::OFF_MODE, 32'hF0);
		rd(pos_pkg::OFF_TRIG_SEL, 32'hFF);
		wr(pos_pkg::OFF_PORT_B, 32'h5A);
		wr(pos_pkg::OFF_DIR, 32'hFF00);
		wr(pos_pkg::OFF_PAT_EN, 32'hFF00);
		wr(pos_pkg::OFF_NEXT_B, 32'h95);
		@(posedge clk);
		chk("hold", 32'h5A00FF00, {pinOut, pinOe});
		fire(16'h8000, 16'h9500);
		wr(pos_pkg::OFF_MODE, 32'h0C);
		rd(pos_pkg::OFF_MODE, 32'hFC);
		wr(pos_pkg::OFF_NEXT_B, 32'h65);
		fire(16'h4000, 16'h0500);
		fire(16'h8000, 16'h6500);
		wr(pos_pkg::OFF_MODE, 32'h00);
		wr(pos_pkg::OFF_NEXT_B, 32'h59);
		fire(16'h2000, 16'h5900);
		wr(pos_pkg::OFF_NEXT_B, 32'h00);
		fire(16'h4000, 16'h5900);
		wr(pos_pkg::OFF_PORT_B, 32'h00);
		rd(pos_pkg::OFF_PORT_B, 32'h59);
		// Only the upper lane is selected: port B direction clears, the low byte stays
		bus(pos_pkg::OFF_DIR, 1'b1, 4'h2, 32'h000000FF, q, e);
		rd(pos_pkg::OFF_DIR, 32'h0);
		wr(pos_pkg::OFF_NEXT_B, 32'hC3);
		fire(16'h8000, 16'hC300);
		chk("oe", 32'h0, {16'h0000, pinOe});
		rd(pos_pkg::OFF_PORT_B, 32'hC3);
		// Groups 0 and 1 move to channel 1; port A bits 7:4 stay inputs
		wr(pos_pkg::OFF_TRIG_SEL, 32'hF5);
		rd(pos_pkg::OFF_TRIG_SEL, 32'hF5);
		wr(pos_pkg::OFF_PORT_A, 32'h3C);
		wr(pos_pkg::OFF_DIR, 32'hFF0F);
		wr(pos_pkg::OFF_PAT_EN, 32'hFFFF);
		wr(pos_pkg::OFF_NEXT_A, 32'hA6);
		wr(pos_pkg::OFF_NEXT_B, 32'h81);
		fire(16'h8000, 16'h813C);
		fire(16'h0080, 16'h81A6);
		chk("oe", 32'hFF0F, {16'h0000, pinOe});
		rd(pos_pkg::OFF_PIN_IN, 32'hC35A);
		claim <= 16'hFF00;
		cOut <= 16'hA5A5;
		cOe <= 16'h3C3C;
		wr(pos_pkg::OFF_NEXT_B, 32'h3C);
		fire(16'h8000, 16'hA5A6);
		chk("oe", 32'h3C0F, {16'h0000, pinOe});
		claim <= 16'h0;
		rd(pos_pkg::OFF_PORT_B, 32'h3C);
		bus(8'h40, 1'b0, 4'hF, 32'h0, q, e);
		chk("unmapped", 32'h1, {31'h0, e});
		// Reset in mid-run must bring pins, mode and trigger select back
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reset pins", 32'h0, {pinOut, pinOe});
		rst_n <= 1'b1;
		rd(pos_pkg::OFF_MODE, 32'hF0);
		rd(pos_pkg::OFF_TRIG_SEL, 32'hFF);
		rd(pos_pkg::OFF_PORT_B, 32'h0);
		stop_test();
	end
endmodule : pos_sequencer_tb_top
`default_nettype wire

// file: dv/pos_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module pos_timer_model (
	input wire logic clk,
	input wire logic [15:0] req,
	output var pos_pkg::pos_evt_t [pos_pkg::NUM_CHANNELS-1:0] timerEvt
);
	// Strobes last one cycle, as the counter compare gives them
	always_ff @(posedge clk) begin
		timerEvt <= req;
	end
endmodule : pos_timer_model
`default_nettype wire

// file: logic/pos_group.sv
`timescale 1ns/1ps
`default_nettype none
module pos_group #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic evtA,
	input wire logic evtB,
	input wire logic nonOverlap,
	input wire logic [WIDTH-1:0] enable,
	input wire logic [WIDTH-1:0] nextBits,
	input wire logic [WIDTH-1:0] swData,
	input wire logic swWrite,
	output logic [WIDTH-1:0] data
);
	logic [WIDTH-1:0] dataQ;
	logic [WIDTH-1:0] dataD;

	if (WIDTH < 1) begin : gBadWidth
		$error("WIDTH must be positive");
	end

	always_comb begin
		dataD = dataQ;
		if (swWrite) begin
			// Software writes land only on bits not under pattern control
			dataD = (dataQ & enable) | (swData & ~enable);
		end
		// Trigger wins over a software write; whole group in one cycle
		if (evtA) begin
			dataD = (dataD & ~enable) | (nextBits & enable);
		end else if (evtB && nonOverlap) begin
			dataD = dataD & ~(enable & ~nextBits);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataQ <= '0;
		end else begin
			dataQ <= dataD;
		end
	end

	assign data = dataQ;
endmodule : pos_group
`default_nettype wire

// file: logic/pos_pkg.sv
// Notes on behaviour
// - Selected trigger copies next bits into port data
// - Falling outputs at B, rising at A
// - Non-overlap: all enabled bits copied at A
// - Non-overlap: only zeros copied at B
// - Input capture triggers like compare match
// - Claimed pin shows its other function
// - Transfer still happens on claimed pins
// - Per-group mode bit, zero is normal, resets zero
// - Enable without direction: input, data still updated
// - Pins show port data until first trigger
package pos_pkg;
	localparam int NUM_GROUPS = 4;
	localparam int GROUP_BITS = 4;
	localparam int NUM_CHANNELS = 4;
	localparam int PINS = NUM_GROUPS * GROUP_BITS;

	// Word offsets on the register bus (byte addresses)
	localparam logic [7:0] OFF_NEXT_A = 8'h00;
	localparam logic [7:0] OFF_NEXT_B = 8'h04;
	localparam logic [7:0] OFF_PORT_A = 8'h08;
	localparam logic [7:0] OFF_PORT_B = 8'h0C;
	localparam logic [7:0] OFF_DIR = 8'h10;
	localparam logic [7:0] OFF_PAT_EN = 8'h14;
	localparam logic [7:0] OFF_TRIG_SEL = 8'h18;
	localparam logic [7:0] OFF_MODE = 8'h1C;
	localparam logic [7:0] OFF_PIN_IN = 8'h20;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
	localparam logic [7:0] MODE_RSVD = 8'hF0;

	// Event strobes from one timer channel
	typedef struct packed {
		logic matchA;
		logic matchB;
		logic captureA;
		logic captureB;
	} pos_evt_t;
endpackage : pos_pkg

// file: logic/pos_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pos_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire pos_pkg::pos_evt_t [pos_pkg::NUM_CHANNELS-1:0] timerEvt,
	input wire logic [pos_pkg::PINS-1:0] pinClaimed,
	input wire logic [pos_pkg::PINS-1:0] claimedOut,
	input wire logic [pos_pkg::PINS-1:0] claimedOe,
	input wire logic [pos_pkg::PINS-1:0] pinIn,
	output logic [pos_pkg::PINS-1:0] pinOut,
	output logic [pos_pkg::PINS-1:0] pinOe
);
	localparam int P = pos_pkg::PINS;
	localparam int G = pos_pkg::NUM_GROUPS;
	localparam int W = pos_pkg::GROUP_BITS;

	logic [P-1:0] nextQ, nextD;
	logic [P-1:0] dirQ, dirD;
	logic [P-1:0] enQ, enD;
	logic [7:0] trigQ, trigD;
	logic [G-1:0] modeQ, modeD;
	logic ackQ, ackD, errQ, errD;
	logic [31:0] rdQ, rdD;
	logic [P-1:0] outQ, outD, oeQ, oeD;
	logic [P-1:0] portData;
	logic [G-1:0] evtA, evtB;
	logic [1:0] portWr;
	logic req;

	if (G * W != P) begin : gBadLayout
		$error("Group layout mismatch");
	end
	if (pos_pkg::NUM_CHANNELS != 4) begin : gBadChannels
		$error("Two-bit channel select needs four channels");
	end

	assign req = wb_cyc_i && wb_stb_i && !ackQ && !errQ;

	// Each group picks one channel; capture counts as a match
	generate
		for (genvar g = 0; g < G; g++) begin : gGroup
			pos_pkg::pos_evt_t ev;
			assign ev = timerEvt[trigQ[2*g +: 2]];
			assign evtA[g] = ev.matchA | ev.captureA;
			assign evtB[g] = ev.matchB | ev.captureB;
			pos_group #(
				.WIDTH(W)
			) uGroup (
				.clk(clk),
				.rst_n(rst_n),
				.evtA(evtA[g]),
				.evtB(evtB[g]),
				.nonOverlap(modeQ[g]),
				.enable(enQ[g*W +: W]),
				.nextBits(nextQ[g*W +: W]),
				// Two groups share one port byte, so lanes repeat per port
				.swData(wb_dat_i[(g % 2)*W +: W]),
				.swWrite(portWr[g/2]),
				.data(portData[g*W +: W])
			);
		end
	endgenerate

	always_comb begin
		nextD = nextQ;
		dirD = dirQ;
		enD = enQ;
		trigD = trigQ;
		modeD = modeQ;
		portWr = 2'b00;
		ackD = 1'b0;
		errD = 1'b0;
		rdD = 32'h00000000;
		if (req) begin
			ackD = 1'b1;
			unique case (wb_adr_i)
				pos_pkg::OFF_NEXT_A: begin
					rdD = {24'h000000, nextQ[7:0]};
					if (wb_we_i && wb_sel_i[0]) nextD[7:0] = wb_dat_i[7:0];
				end
				pos_pkg::OFF_NEXT_B: begin
					rdD = {24'h000000, nextQ[15:8]};
					if (wb_we_i && wb_sel_i[0]) nextD[15:8] = wb_dat_i[7:0];
				end
				pos_pkg::OFF_PORT_A: begin
					rdD = {24'h000000, portData[7:0]};
					portWr[0] = wb_we_i && wb_sel_i[0];
				end
				pos_pkg::OFF_PORT_B: begin
					rdD = {24'h000000, portData[15:8]};
					portWr[1] = wb_we_i && wb_sel_i[0];
				end
				pos_pkg::OFF_DIR: begin
					rdD = {16'h0000, dirQ};
					if (wb_we_i && wb_sel_i[0]) dirD[7:0] = wb_dat_i[7:0];
					if (wb_we_i && wb_sel_i[1]) dirD[15:8] = wb_dat_i[15:8];
				end
				pos_pkg::OFF_PAT_EN: begin
					rdD = {16'h0000, enQ};
					if (wb_we_i && wb_sel_i[0]) enD[7:0] = wb_dat_i[7:0];
					if (wb_we_i && wb_sel_i[1]) enD[15:8] = wb_dat_i[15:8];
				end
				pos_pkg::OFF_TRIG_SEL: begin
					rdD = {24'h000000, trigQ};
					if (wb_we_i && wb_sel_i[0]) trigD = wb_dat_i[7:0];
				end
				pos_pkg::OFF_MODE: begin
					rdD = {24'h000000, pos_pkg::MODE_RSVD | {4'h0, modeQ}};
					if (wb_we_i && wb_sel_i[0]) modeD = wb_dat_i[3:0];
				end
				pos_pkg::OFF_PIN_IN: begin
					rdD = {16'h0000, pinIn};
				end
				default: begin
					ackD = 1'b0;
					errD = 1'b1;
				end
			endcase
		end
	end

	// Pin drive: claimed pins follow their owner; else port data when direction set
	always_comb begin
		for (int i = 0; i < P; i++) begin
			if (pinClaimed[i]) begin
				outD[i] = claimedOut[i];
				oeD[i] = claimedOe[i];
			end else begin
				outD[i] = portData[i];
				oeD[i] = dirQ[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nextQ <= '0;
			dirQ <= '0;
			enQ <= '0;
			trigQ <= pos_pkg::RST_TRIG_SEL;
			modeQ <= '0;
			ackQ <= 1'b0;
			errQ <= 1'b0;
			rdQ <= 32'h00000000;
			outQ <= '0;
			oeQ <= '0;
		end else begin
			nextQ <= nextD;
			dirQ <= dirD;
			enQ <= enD;
			trigQ <= trigD;
			modeQ <= modeD;
			ackQ <= ackD;
			errQ <= errD;
			rdQ <= rdD;
			outQ <= outD;
			oeQ <= oeD;
		end
	end

	assign wb_ack_o = ackQ;
	assign wb_err_o = errQ;
	assign wb_dat_o = rdQ;
	assign pinOut = outQ;
	assign pinOe = oeQ;
endmodule : pos_sequencer
`default_nettype wire
